// [rtl/two_wire_eeprom.sv]
`timescale 1ns/100ps
// Function
// - 32768 bytes, 15-bit internal address
// - Works with SCL up to 1 MHz
// - Full or partial 64-byte page writes
// - Random and sequential reads supported
// - Self-timed programming within 5 ms
// - Hardware input protects whole array
// - Guard high blocks writes, low allows
// - Respond only when straps match address
// - Undriven straps and guard read low
// - SDA open drain: pull low or release
// - Sample SDA on SCL rising edge
// - Change read data after SCL falling
module two_wire_eeprom
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WR_CYCLES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Serial bus
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Straps and guard
  input  wire logic address_strap_bit0,
  input  wire logic address_strap_bit1,
  input  wire logic address_strap_bit2,
  input  wire logic write_guard
);
  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  logic [SYNC_STAGES:0]   scl_s;
  logic [SYNC_STAGES:0]   sda_s;
  logic [SYNC_STAGES-1:0] strap_s [3];
  logic [SYNC_STAGES-1:0] guard_s;
  logic [2:0]             strap_pins;
  logic [2:0]             strap;
  logic                   guard;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_cond;
  logic                   stop_cond;

  assign strap_pins = {address_strap_bit2, address_strap_bit1, address_strap_bit0};

  // Three stages: two to settle, the third only for edge finding; fine up to 1 MHz SCL
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_s <= '1;
      sda_s <= '1;
    end else begin
      scl_s <= {scl_s[SYNC_STAGES-1:0], scl_in};
      sda_s <= {sda_s[SYNC_STAGES-1:0], sda_in};
    end
  end

  // Straps and guard reset to low, as an undriven pin is pulled down
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_strap
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          strap_s[gi] <= '0;
        end else begin
          strap_s[gi] <= {strap_s[gi][0], strap_pins[gi]};
        end
      end
      assign strap[gi] = strap_s[gi][SYNC_STAGES-1];
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      guard_s <= '0;
    end else begin
      guard_s <= {guard_s[0], write_guard};
    end
  end
  assign guard = guard_s[SYNC_STAGES-1];

  // Edges and bus conditions, from settled stages only
  assign scl_rise   = scl_s[1] & ~scl_s[2];
  assign scl_fall   = ~scl_s[1] & scl_s[2];
  assign start_cond = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign stop_cond  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // ***************************************************
  // Protocol engine
  // ***************************************************
  state_t              state;
  logic [3:0]          bit_cnt;
  logic [1:0]          byte_no;
  logic [DATA_W-1:0]   shreg;
  logic [DATA_W-1:0]   tx_sh;
  logic [ADDR_W-1:0]   ptr;
  logic                rw;
  logic                master_ack;
  logic                wrote;
  logic                busy;
  logic [31:0]         busy_cnt;
  logic                sel_match;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic [FIFO_W-1:0]   fifo_in_data;
  logic [DATA_W-1:0]   rd_q;
  logic                byte_done;

  assign sda_out   = 1'b0;
  assign byte_done = scl_fall & (bit_cnt == 4'h8);
  assign sel_match = (shreg[7:SEL_TYPE_LSB] == DEV_TYPE) &
                     (shreg[3:1] == strap) & ~busy;

  // Push a data byte at the ack decision; a full buffer refuses with NACK
  assign fifo_in_valid = (state == ST_RX) & byte_done & (byte_no == BYTE_DAT);
  assign fifo_in_data  = {ptr, shreg};

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state      <= ST_IDLE;
      bit_cnt    <= '0;
      byte_no    <= BYTE_SEL;
      shreg      <= '0;
      tx_sh      <= '0;
      ptr        <= '0;
      rw         <= 1'b0;
      master_ack <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (start_cond) begin
      state   <= ST_RX;   // Repeated start also lands here
      bit_cnt <= '0;
      byte_no <= BYTE_SEL;
      sda_oe  <= 1'b0;
    end else if (stop_cond) begin
      state  <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s[1]};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= '0;
            state   <= ST_ACK;
            sda_oe  <= 1'b1;
            case (byte_no)
              BYTE_SEL: begin
                rw <= shreg[SEL_RW_BIT];
                if (!sel_match) begin
                  state  <= ST_IDLE;
                  sda_oe <= 1'b0;
                end
              end
              BYTE_HI: ptr[ADDR_W-1:8] <= shreg[ADDR_W-9:0];
              BYTE_LO: ptr[7:0] <= shreg;
              default: begin
                if (fifo_in_ready) begin
                  // Roll over inside the page, never into the next one
                  ptr[PAGE_W-1:0] <= ptr[PAGE_W-1:0] + 1'b1;
                end else begin
                  state  <= ST_IDLE;
                  sda_oe <= 1'b0;
                end
              end
            endcase
            if (byte_no != BYTE_DAT) begin
              byte_no <= byte_no + 2'h1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              // First read bit goes out right after the ack clock falls
              state   <= ST_TX;
              tx_sh   <= rd_q;
              sda_oe  <= ~rd_q[7];
              bit_cnt <= 4'h1;
              ptr     <= ptr + 1'b1;
            end else begin
              state  <= ST_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              state  <= ST_RACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe  <= ~tx_sh[6];
              tx_sh   <= {tx_sh[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            master_ack <= ~sda_s[1];
          end else if (scl_fall) begin
            if (master_ack) begin
              state   <= ST_TX;   // Sequential read continues
              tx_sh   <= rd_q;
              sda_oe  <= ~rd_q[7];
              bit_cnt <= 4'h1;
              ptr     <= ptr + 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ***************************************************
  // Write buffer and array
  // ***************************************************
  logic                drain_valid;
  logic                drain_ready;
  logic [FIFO_W-1:0]   drain_data;
  logic [DATA_W-1:0]   mem [MEM_WORDS];

  // Drain stalls while a read byte is shifted out or its ack is taken (ST_TX, ST_RACK)
  assign drain_ready = ~(state == ST_TX | state == ST_RACK);

  write_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  // Guard drops buffered bytes rather than storing them
  always_ff @(posedge mclk) begin
    if (drain_valid & drain_ready & ~guard) begin
      mem[drain_data[FIFO_W-1:DATA_W]] <= drain_data[DATA_W-1:0];
    end
    rd_q <= mem[ptr];
  end

  // ***************************************************
  // Self-timed write cycle
  // ***************************************************
  // Busy only when a byte was really accepted for writing
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrote <= 1'b0;
    end else if (start_cond & (state == ST_IDLE)) begin
      wrote <= 1'b0;
    end else if (fifo_in_valid & fifo_in_ready & ~guard) begin
      wrote <= 1'b1;
    end else if (stop_cond) begin
      wrote <= 1'b0;
    end
  end

  // Device ignores its address while programming runs
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      busy_cnt <= '0;
      busy     <= 1'b0;
    end else if (stop_cond & wrote) begin
      busy_cnt <= 32'(WRITE_CYCLES);
      busy     <= 1'b1;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - 32'h1;
      busy     <= (busy_cnt != 32'h1);
    end
  end
endmodule

// [rtl/eeprom_pkg.sv]
package eeprom_pkg;
  // ***************************************************
  // Array geometry
  // ***************************************************
  localparam int ADDR_W    = 15;
  localparam int MEM_WORDS = 32768;
  localparam int DATA_W    = 8;
  localparam int PAGE_W    = 6;
  localparam int PAGE_SIZE = 64;

  // ***************************************************
  // Bus speed and timing
  // ***************************************************
  localparam int CLK_KHZ      = 25000;
  localparam int SCL_STD_KHZ  = 100;
  localparam int SCL_FAST_KHZ = 400;
  localparam int SCL_PLUS_KHZ = 1000;
  localparam int T_WR_MS      = 5;
  localparam int WR_CYCLES    = T_WR_MS * CLK_KHZ;
  localparam int SYNC_STAGES  = 2;

  // ***************************************************
  // Selection byte layout and buffering
  // ***************************************************
  localparam logic [3:0] DEV_TYPE   = 4'hA;
  localparam int         SEL_TYPE_LSB = 4;
  localparam int         SEL_RW_BIT   = 0;
  localparam int         FIFO_DEPTH = 4;
  localparam int         FIFO_W     = ADDR_W + DATA_W;

  // ***************************************************
  // Protocol states
  // ***************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_RACK = 5'h10
  } state_t;

  // Byte position within a frame
  localparam logic [1:0] BYTE_SEL = 2'h0;
  localparam logic [1:0] BYTE_HI  = 2'h1;
  localparam logic [1:0] BYTE_LO  = 2'h2;
  localparam logic [1:0] BYTE_DAT = 2'h3;
endpackage

// [rtl/write_fifo.sv]
`timescale 1ns/100ps
module write_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  // ***************************************************
  // Handshakes
  // ***************************************************
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = store[rd_ptr];

  // Storage written only on push
  always_ff @(posedge mclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// [verification/two_wire_eeprom_properties.sv]
`timescale 1ns/100ps
module eeprom_checker
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WR_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Straps and guard
  input wire logic address_strap_bit0,
  input wire logic address_strap_bit1,
  input wire logic address_strap_bit2,
  input wire logic write_guard
);
  // ****************
  // Helper history
  // ****************
  logic [3:0] scl_hist;
  logic [6:0] low_run;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Recent bus clock samples
  always_ff @(posedge mclk) begin
    scl_hist <= {scl_hist[2:0], scl_in};
  end
  // Unbroken pull length; a stuck enable grows it
  always_ff @(posedge mclk) begin
    if (!rst_b || !sda_oe) begin
      low_run <= 7'h00;
    end else if (low_run != 7'h7F) begin
      low_run <= low_run + 7'h01;
    end
  end
  property p_drive_zero; sda_out == 1'b0; endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("data drives high");
  property p_quiet_reset; $rose(rst_b) |-> !sda_oe [*4]; endproperty
  a_quiet_reset: assert property (p_quiet_reset) else $error("pull after reset");
  property p_after_fall; $changed(sda_oe) |-> scl_hist != 4'hF; endproperty
  a_after_fall: assert property (p_after_fall) else $error("change not after fall");
  property p_still_high; scl_in && scl_hist[2:0] == 3'h7 |-> $stable(sda_oe); endproperty
  a_still_high: assert property (p_still_high) else $error("change in high");
  property p_hold_bit; $rose(sda_oe) |-> sda_oe [*6]; endproperty
  a_hold_bit: assert property (p_hold_bit) else $error("pull too short");
  property p_run_bound; low_run < 7'h50; endproperty
  a_run_bound: assert property (p_run_bound) else $error("pull too long");
  property p_start_free; scl_in && $fell(sda_in) |-> !sda_oe [*4]; endproperty
  a_start_free: assert property (p_start_free) else $error("pull at start");
  property p_stop_free; scl_in && $rose(sda_in) |-> !sda_oe [*4]; endproperty
  a_stop_free: assert property (p_stop_free) else $error("pull at stop");
  // Every pull change lands a fixed three samples after a clock fall
  property p_fall_delay; $changed(sda_oe) |-> scl_hist == 4'h8; endproperty
  a_fall_delay: assert property (p_fall_delay) else $error("change off fall delay");
endmodule
bind two_wire_eeprom eeprom_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_bit0(address_strap_bit0),
  .address_strap_bit1(address_strap_bit1), .address_strap_bit2(address_strap_bit2),
  .write_guard(write_guard));

// [verification/bus_controller_model.sv]
`timescale 1ns/100ps
module bus_controller_model (
  // Clock and bus
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  int pace = 2;
  // Idle bus: clock parked high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bit; pace 2 gives the 320 ns period
  task automatic qtr();
    repeat (pace) @(negedge mclk);
  endtask
  // One bit, sampled in mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    qtr();
    scl = 1'b1;
    qtr();
    r = sda;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  task automatic start();
    sda_low = 1'b0;
    qtr();
    scl = 1'b1;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl = 1'b0;
    qtr();
  endtask
  // Stop leaves the clock standing high
  task automatic stop();
    sda_low = 1'b1;
    qtr();
    scl = 1'b1;
    qtr();
    sda_low = 1'b0;
    repeat (2) qtr();
  endtask
  // Eight bits first high, then the ninth
  task automatic byte_io(input logic [7:0] d, input logic b9, output logic [7:0] r,
                         output logic r9);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(b9, r9);
  endtask
endmodule

// [verification/two_wire_eeprom_test.sv]
`timescale 1ns/100ps
module two_wire_eeprom_test
  import eeprom_pkg::*;
;
  localparam int WCYC = 200;
  logic       mclk;
  logic       rst_b;
  logic [2:0] strap;
  logic       guard;
  logic       scl;
  logic       ctl_low;
  logic       sda_oe;
  logic       sda_out;
  int         mismatches = 0;
  int         checks = 0;
  int         cycles = 0;
  // Pull-up wins unless a party pulls low
  wire sda = !(ctl_low || (sda_oe && !sda_out));
  two_wire_eeprom #(.WRITE_CYCLES(WCYC)) dut (
    .mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_strap_bit0(strap[0]), .address_strap_bit1(strap[1]),
    .address_strap_bit2(strap[2]), .write_guard(guard));
  bus_controller_model ctl (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(ctl_low));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = !mclk;
  end
  task automatic stop_test();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ack(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // Byte out; ack as seen on the wire
  task automatic put(input logic [7:0] d, output logic ack);
    logic [7:0] r;
    logic r9;
    ctl.byte_io(d, 1'b1, r, r9);
    ack = !r9;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r9;
    ctl.byte_io(8'hFF, last, d, r9);
  endtask
  // Page write, data steps by 8'h11
  task automatic write_at(input logic [14:0] ad, input logic [7:0] d0, input int n);
    logic a;
    ctl.start();
    put({DEV_TYPE, strap, 1'b0}, a);
    put({1'b0, ad[14:8]}, a);
    put(ad[7:0], a);
    for (int i = 0; i < n; i++) begin
      put(d0 + 8'(i * 17), a);
      chk_ack(a, 1'b1);
    end
    ctl.stop();
  endtask
  task automatic read_at(input logic [14:0] ad, input logic [7:0] d0, input int n);
    logic a;
    logic [7:0] d;
    ctl.start();
    put({DEV_TYPE, strap, 1'b0}, a);
    chk_ack(a, 1'b1);
    put({1'b0, ad[14:8]}, a);
    put(ad[7:0], a);
    ctl.start();
    put({DEV_TYPE, strap, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      get(i == n - 1, d);
      chk_byte(d, d0 + 8'(i * 17));
    end
    ctl.stop();
  endtask
  // Only the strapped select is answered, for two strap settings
  task automatic t_select();
    logic a;
    for (int p = 0; p < 2; p++) begin
      strap = (p == 0) ? 3'h2 : 3'h5;
      // Straps pass a synchroniser before the compare sees them
      repeat (4) @(negedge mclk);
      for (int s = 0; s < 8; s++) begin
        ctl.start();
        put({DEV_TYPE, 3'(s), 1'b0}, a);
        ctl.stop();
        chk_ack(a, 3'(s) == strap);
      end
    end
  endtask
  // Write across page end, busy, then read back
  task automatic t_page();
    logic a;
    write_at(15'h7FFE, 8'hA1, 3);
    ctl.start();
    put({DEV_TYPE, strap, 1'b0}, a);
    ctl.stop();
    chk_ack(a, 1'b0);
    repeat (WCYC) @(negedge mclk);
    read_at(15'h7FFE, 8'hA1, 2);
    read_at(15'h7FC0, 8'hC3, 1);
  endtask
  // Guarded write dropped, no busy; slow bus and current read
  task automatic t_guard();
    logic [7:0] d;
    logic a;
    guard = 1'b1;
    ctl.pace = 4;
    write_at(15'h7FFE, 8'h55, 1);
    read_at(15'h7FFE, 8'hA1, 1);
    guard = 1'b0;
    ctl.start();
    put({DEV_TYPE, strap, 1'b1}, a);
    get(1'b1, d);
    ctl.stop();
    chk_byte(d, 8'hB2);
    ctl.pace = 2;
  endtask
  initial begin
    rst_b = 1'b0;
    strap = 3'h5;
    guard = 1'b0;
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
    t_select();
    t_page();
    t_guard();
    stop_test();
  end
endmodule
